// ---- logic/scs_sequencer.sv ----
// sar conversion sequencer: acquisition, binary search, code, readout
//
// Behaviour
// - host raises convert_start after acquisition; rising edge starts a conversion
// - during acquisition both ground switches closed, all array switches on inputs
// - conversion start opens ground switches first, then arrays leave inputs, keeping the previous search pattern until the search starts
// - value captured at end of acquisition is converted; later changes ignored
// - msb-first binary search over 18 array elements, ground or reference per decision
// - after last decision return to acquisition, produce code, signal via busy
// - decisions timed by internal conversion clock, no serial clock needed
// - result belongs to the same conversion, no pipeline latency
// - supports up to 1,330,000 conversions per second
// - output code is 18-bit two's complement around zero
// - positive full scale and over-range saturate at 0x1FFFF
// - negative full scale and under-range give 0x20000
// - result shifted on serial_result_out with the external serial clock
`timescale 1ns/1ps
module scs_sequencer
  import scs_pkg::*;
#(
  parameter int BITS     = SCS_BITS,
  parameter int CONV_DIV = SCS_CONV_DIV
)
(
  input  wire logic            clk,                          // 250 MHz clock
  input  wire logic            sys_rst,                      // async reset, high
  input  wire logic            convert_start,                // host convert pin
  input  wire logic            comparator_high,              // comparator: trial too low, keep bit
  input  wire logic            over_range,                   // analog over-range detect
  input  wire logic            under_range,                  // analog under-range detect
  input  wire logic            serial_clk,                   // external serial clock pin
  output logic                 pos_comparator_ground_switch, // closed when high
  output logic                 neg_comparator_ground_switch, // closed when high
  output logic                 array_to_input,               // array switches on analog inputs
  output logic [BITS-1:0]      array_to_ref,                 // element on reference when high
  output logic                 busy,                         // conversion in progress
  output logic                 result_valid,                 // one-cycle pulse: new result
  output logic [BITS-1:0]      result,                       // held output code
  output logic                 serial_result_out             // serial result bit
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] cnv_sync_q;
  logic [1:0] cnv_sync_d;
  logic [1:0] sck_sync_q;
  logic [1:0] sck_sync_d;
  logic       cnv_prev_q;
  logic       sck_prev_q;
  logic       cnv_rise;
  logic       sck_rise;

  always_comb
  begin
    cnv_sync_d = {cnv_sync_q[0], convert_start};
    sck_sync_d = {sck_sync_q[0], serial_clk};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnv_sync_q <= 2'h0;
      sck_sync_q <= 2'h0;
      cnv_prev_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      cnv_sync_q <= cnv_sync_d;
      sck_sync_q <= sck_sync_d;
      cnv_prev_q <= cnv_sync_q[1];
      sck_prev_q <= sck_sync_q[1];
    end
  end

  assign cnv_rise = cnv_sync_q[1] & ~cnv_prev_q;
  assign sck_rise = sck_sync_q[1] & ~sck_prev_q;

  // ------------------------------------------------------------
  // internal conversion clock enable
  // ------------------------------------------------------------
  // free-running divider; restarted at hold so every bit gets a full period
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic       conv_tick;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  scs_state_t      st_q;
  scs_state_t      st_d;
  logic [4:0]      bit_q;
  logic [4:0]      bit_d;
  logic [BITS-1:0] dac_q;
  logic [BITS-1:0] dac_d;
  logic [BITS-1:0] res_q;
  logic [BITS-1:0] res_d;
  logic            ovr_q;
  logic            ovr_d;
  logic            und_q;
  logic            und_d;
  logic            gnd_sw_q;
  logic            gnd_sw_d;
  logic            arr_in_q;
  logic            arr_in_d;
  logic            busy_q;
  logic            busy_d;
  logic            vld_q;
  logic            vld_d;

  assign conv_tick = (div_q == 4'(CONV_DIV - 1));

  // offset-binary search result to two's complement, with saturation
  function automatic logic [BITS-1:0] to_code(input logic [BITS-1:0] raw,
                                               input logic ovr,
                                               input logic und);
    if (ovr)
      to_code = SCS_CODE_POS_MAX;
    else if (und)
      to_code = SCS_CODE_NEG_MIN;
    else
      to_code = {~raw[BITS-1], raw[BITS-2:0]};
  endfunction : to_code

  always_comb
  begin
    st_d     = st_q;
    bit_d    = bit_q;
    dac_d    = dac_q;
    res_d    = res_q;
    ovr_d    = ovr_q;
    und_d    = und_q;
    gnd_sw_d = gnd_sw_q;
    arr_in_d = arr_in_q;
    busy_d   = busy_q;
    vld_d    = 1'b0;
    div_d    = conv_tick ? 4'h0 : div_q + 4'h1;
    unique case (st_q)
      SCS_ACQ:
      begin
        gnd_sw_d = 1'b1;
        arr_in_d = 1'b1;
        if (cnv_rise)
        begin
          gnd_sw_d = 1'b0;
          busy_d   = 1'b1;
          st_d     = SCS_OPEN_GS;
        end
      end
      SCS_OPEN_GS:
      begin
        // arrays leave inputs a cycle after ground switches open; the sample freezes here
        arr_in_d = 1'b0;
        ovr_d    = over_range;
        und_d    = under_range;
        st_d     = SCS_HOLD;
      end
      SCS_HOLD:
      begin
        div_d = 4'h0;
        bit_d = SCS_BIT_MSB;
        dac_d = SCS_DAC_RESET;
        dac_d[BITS-1] = 1'b1;
        st_d  = SCS_CONV;
      end
      SCS_CONV:
      begin
        if (conv_tick)
        begin
          dac_d[bit_q] = comparator_high;
          if (bit_q == 5'h00)
            st_d = SCS_DONE;
          else
          begin
            dac_d[bit_q - 5'h01] = 1'b1;
            bit_d = bit_q - 5'h01;
          end
        end
      end
      SCS_DONE:
      begin
        gnd_sw_d = 1'b1;
        arr_in_d = 1'b1;
        res_d    = to_code(dac_q, ovr_q, und_q);
        vld_d    = 1'b1;
        busy_d   = 1'b0;
        st_d     = SCS_ACQ;
      end
      default:
        st_d = SCS_ACQ;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q     <= SCS_ACQ;
      bit_q    <= SCS_BIT_MSB;
      dac_q    <= SCS_DAC_RESET;
      res_q    <= SCS_RESULT_RESET;
      ovr_q    <= 1'b0;
      und_q    <= 1'b0;
      gnd_sw_q <= 1'b1;
      arr_in_q <= 1'b1;
      busy_q   <= 1'b0;
      vld_q    <= 1'b0;
      div_q    <= 4'h0;
    end
    else
    begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      dac_q    <= dac_d;
      res_q    <= res_d;
      ovr_q    <= ovr_d;
      und_q    <= und_d;
      gnd_sw_q <= gnd_sw_d;
      arr_in_q <= arr_in_d;
      busy_q   <= busy_d;
      vld_q    <= vld_d;
      div_q    <= div_d;
    end
  end

  assign pos_comparator_ground_switch = gnd_sw_q;
  assign neg_comparator_ground_switch = gnd_sw_q;
  assign array_to_input               = arr_in_q;
  assign array_to_ref                 = dac_q;
  assign busy                         = busy_q;
  assign result_valid                 = vld_q;
  assign result                       = res_q;

  // ------------------------------------------------------------
  // serial readout
  // ------------------------------------------------------------
  scs_shift_out #(.W(BITS)) u_shift
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .load       (vld_d),
    .word       (res_d),
    .sck_rise   (sck_rise),
    .serial_out (serial_result_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // start edge to sampled valid: open, hold, done and valid register, plus one tick period per bit
  localparam int CONV_CYC = 4 + BITS * CONV_DIV;

  sequence s_start;
    cnv_rise && st_q == SCS_ACQ;
  endsequence

  sequence s_open_then_hold;
    ##1 (!gnd_sw_q && arr_in_q) ##1 (!gnd_sw_q && !arr_in_q);
  endsequence

  a_acq_switches: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == SCS_ACQ |-> gnd_sw_q && arr_in_q)
    else $error("acquisition switches wrong");

  a_open_order: assert property (@(posedge clk) disable iff (sys_rst)
    s_start |-> s_open_then_hold)
    else $error("ground switches not opened before arrays released");

  a_start_busy: assert property (@(posedge clk) disable iff (sys_rst)
    s_start |=> busy_q)
    else $error("busy not raised on convert edge");

  a_done_in_time: assert property (@(posedge clk) disable iff (sys_rst)
    s_start |-> ##[3:CONV_CYC] vld_q)
    else $error("conversion did not complete in time");

  a_rate_ok: assert property (@(posedge clk) disable iff (sys_rst)
    CONV_CYC < SCS_PERIOD_CYC)
    else $error("conversion too slow for max rate");

  a_valid_idle: assert property (@(posedge clk) disable iff (sys_rst)
    vld_q |-> !busy_q && st_q == SCS_ACQ && gnd_sw_q)
    else $error("completion without return to acquisition");

  a_result_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !vld_q |-> res_q == $past(res_q))
    else $error("result changed outside completion");

  a_sat_pos: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == SCS_DONE && ovr_q |=> res_q == SCS_CODE_POS_MAX)
    else $error("over-range not saturated");

  a_sat_neg: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == SCS_DONE && !ovr_q && und_q |=> res_q == SCS_CODE_NEG_MIN)
    else $error("under-range not at minimum");

  a_code_map: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == SCS_DONE && !ovr_q && !und_q |=> res_q == {~$past(dac_q[17]), $past(dac_q[16:0])})
    else $error("two's complement mapping wrong");

  a_msb_first: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == SCS_HOLD |=> bit_q == SCS_BIT_MSB && dac_q == 18'h20000)
    else $error("search not starting at msb");

  a_sample_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == SCS_CONV |-> !arr_in_q && $stable(ovr_q) && $stable(und_q))
    else $error("sample not held during conversion");

endmodule : scs_sequencer

// ---- logic/scs_shift_out.sv ----
// serial result shifter clocked by the sampled external serial clock
`timescale 1ns/1ps
module scs_shift_out
  import scs_pkg::*;
#(
  parameter int W = 18
)
(
  input  wire logic         clk,         // system clock
  input  wire logic         sys_rst,     // async reset, high
  input  wire logic         load,        // load new result word
  input  wire logic [W-1:0] word,        // result word
  input  wire logic         sck_rise,    // synchronised serial clock edge
  output logic              serial_out   // serial data, msb first
);

  logic [W-1:0] sh_q;
  logic [W-1:0] sh_d;

  always_comb
  begin
    sh_d = sh_q;
    if (load)
      sh_d = word;
    else if (sck_rise)
      sh_d = {sh_q[W-2:0], 1'b0};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sh_q <= '0;
    else
      sh_q <= sh_d;
  end

  assign serial_out = sh_q[W-1];

endmodule : scs_shift_out

// ---- shared/scs_pkg.sv ----
// package: constants and types for the sar conversion sequencer
package scs_pkg;

  localparam int              SCS_BITS          = 18;
  localparam int              SCS_CLK_MHZ       = 250;
  localparam int              SCS_MAX_RATE_SPS  = 1330000;
  // one conversion period at max rate, in cycles (rounded down)
  localparam int              SCS_PERIOD_CYC    = (SCS_CLK_MHZ * 1000000) / SCS_MAX_RATE_SPS;
  // conversion clock divider: one enable per bit decision
  localparam int              SCS_CONV_DIV      = 4;
  localparam int              SCS_SETTLE_CYC    = 1;
  localparam logic [17:0]     SCS_CODE_ZERO     = 18'h00000;
  localparam logic [17:0]     SCS_CODE_POS_MAX  = 18'h1FFFF;
  localparam logic [17:0]     SCS_CODE_NEG_MIN  = 18'h20000;
  localparam logic [17:0]     SCS_DAC_RESET     = 18'h00000;
  localparam logic [17:0]     SCS_RESULT_RESET  = 18'h00000;
  localparam logic [4:0]      SCS_BIT_MSB       = 5'h11;

  typedef enum logic [2:0]
  {
    SCS_ACQ     = 3'b000,
    SCS_OPEN_GS = 3'b001,
    SCS_HOLD    = 3'b010,
    SCS_CONV    = 3'b011,
    SCS_DONE    = 3'b100
  } scs_state_t;

endpackage : scs_pkg

// ---- test/scs_analog_model.sv ----
// analog front end model: track and hold plus comparator
`timescale 1ns/1ps
module scs_analog_model
  import scs_pkg::*;
(
  input  wire logic        clk,      // system clock
  input  wire logic        track,    // arrays on analog inputs
  input  wire logic [17:0] trial,    // array reference pattern
  input  wire logic [17:0] vin,      // differential input as a code
  output logic             cmp_high  // trial not above sample
);
  logic [17:0] held_q;

  // ----------------------------------------
  // hold: sample frozen once arrays leave inputs
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (track)
      held_q <= vin ^ SCS_CODE_NEG_MIN;
  end

  // offset binary compare, so the search sees an unsigned scale
  assign cmp_high = (trial <= held_q);
endmodule : scs_analog_model

// ---- test/scs_sequencer_test.sv ----
// self-checking bench for the sar conversion sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module scs_sequencer_test
  import scs_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  logic        convert_start;
  logic        comparator_high;
  logic        over_range;
  logic        under_range;
  logic        serial_clk;
  logic [17:0] vin;
  logic        pos_gs;
  logic        neg_gs;
  logic        array_to_input;
  logic [17:0] array_to_ref;
  logic        busy;
  logic        result_valid;
  logic [17:0] result;
  logic        serial_result_out;
  logic [17:0] exp_w;
  logic [17:0] r;
  logic [17:0] expq[$];
  int          failures;
  int          tests_run;
  localparam logic [17:0] CODES [6] = '{18'h00000, 18'h00001, 18'h3FFFF, 18'h1FFFF, 18'h20001, 18'h20000};

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  scs_sequencer scs_sequencer_inst (
    .clk                          (clk),
    .sys_rst                      (sys_rst),
    .convert_start                (convert_start),
    .comparator_high              (comparator_high),
    .over_range                   (over_range),
    .under_range                  (under_range),
    .serial_clk                   (serial_clk),
    .pos_comparator_ground_switch (pos_gs),
    .neg_comparator_ground_switch (neg_gs),
    .array_to_input               (array_to_input),
    .array_to_ref                 (array_to_ref),
    .busy                         (busy),
    .result_valid                 (result_valid),
    .result                       (result),
    .serial_result_out            (serial_result_out)
  );

  scs_analog_model scs_analog_model_inst (
    .clk      (clk),
    .track    (array_to_input),
    .trial    (array_to_ref),
    .vin      (vin),
    .cmp_high (comparator_high)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic complete_run();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // one conversion, then a full serial readout of its code
  task automatic convert(input logic [17:0] v, input logic ov, input logic un, input logic [17:0] e);
    int          n;
    logic [17:0] got;
    vin = v;
    over_range = ov;
    under_range = un;
    expq.push_back(e);
    convert_start = 1'b1;
    n = 0;
    while (pos_gs === 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    `CHK("array_to_input", 1'b1, array_to_input)
    `CHK("neg_gnd_switch", 1'b0, neg_gs)
    step(1);
    n++;
    `CHK("array_to_input", 1'b0, array_to_input)
    `CHK("busy", 1'b1, busy)
    vin = ~v;
    convert_start = 1'b0;
    step(10);
    // edge while busy must be ignored, else an extra result shows up
    convert_start = 1'b1;
    step(5);
    convert_start = 1'b0;
    n += 16;
    while (result_valid !== 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    `CHK("fast_enough", 1'b1, n <= SCS_PERIOD_CYC)
    `CHK("busy", 1'b0, busy)
    `CHK("pos_gnd_switch", 1'b1, pos_gs)
    `CHK("neg_gnd_switch", 1'b1, neg_gs)
    `CHK("array_to_input", 1'b1, array_to_input)
    // search ends on the held sample in offset binary, whatever the range flags say
    `CHK("search_word", v ^ SCS_CODE_NEG_MIN, array_to_ref)
    for (int i = 17; i >= 0; i--)
    begin
      got[i] = serial_result_out;
      serial_clk = 1'b1;
      step(6);
      serial_clk = 1'b0;
      step(6);
    end
    `CHK("serial_word", e, got)
    `CHK("held_result", e, result)
  endtask : convert

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (sys_rst === 1'b0 && result_valid === 1'b1)
    begin
      exp_w = (expq.size() != 0) ? expq.pop_front() : {18{1'bx}};
      `CHK("result", exp_w, result)
    end
  end

  initial
  begin
    #100000;
    failures++;
    complete_run();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    failures = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    convert_start = 1'b0;
    over_range = 1'b0;
    under_range = 1'b0;
    serial_clk = 1'b0;
    vin = 18'h00000;
    void'($urandom(23847));
    step(2);
    sys_rst = 1'b0;
    step(2);
    for (int i = 0; i < 6; i++)
      convert(CODES[i], 1'b0, 1'b0, CODES[i]);
    convert(18'h00123, 1'b1, 1'b0, SCS_CODE_POS_MAX);
    convert(18'h3FF00, 1'b0, 1'b1, SCS_CODE_NEG_MIN);
    repeat (4)
    begin
      r = 18'($urandom());
      convert(r, 1'b0, 1'b0, r);
    end
    step(5);
    // every noted result must have been seen exactly once
    `CHK("pending_results", 0, expq.size())
    complete_run();
  end
endmodule : scs_sequencer_test
